/* pin_routing_pkg.sv */
// pin_routing_pkg: constants for the remappable pin routing block
// assumes a 16-bit register port addressed by word index
package pin_routing_pkg;

  localparam int NUM_PINS   = 16;
  localparam int NUM_IN     = 14;
  localparam int NUM_POUT   = 7;
  localparam int SEL_W      = 5;
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 6;
  localparam int CFG_W      = 8;
  localparam int IMAGE_W    = (NUM_IN + NUM_PINS) * SEL_W;

  ////////////////////////////////////////////////////////////////////////////
  // register map (word index)
  localparam logic [5:0] IN_ROUTE_BASE  = 6'h00;
  localparam logic [5:0] IN_ROUTE_LAST  = 6'h08;
  localparam logic [5:0] OUT_ROUTE_BASE = 6'h10;
  localparam logic [5:0] OUT_ROUTE_LAST = 6'h17;
  localparam logic [5:0] OSC_CTRL_ADDR  = 6'h20;
  localparam int         LOCK_BIT       = 6;
  localparam int         FUSE_BIT       = 5;
  localparam int         OUT_HI_LSB     = 8;

  // input field table, order: int1 int2 t2ck t3ck ic1 ic2 ic7 ic8
  // compare_fault_a_in rx cts sdi sck ss
  localparam logic [5:0] IN_REG_ADDR [NUM_IN] = '{
    6'h00, 6'h01, 6'h02, 6'h02, 6'h03, 6'h03, 6'h04,
    6'h04, 6'h05, 6'h06, 6'h06, 6'h07, 6'h07, 6'h08};
  localparam int IN_LSB [NUM_IN] = '{
    8, 0, 0, 8, 0, 8, 0, 8, 0, 0, 8, 0, 8, 0};

  ////////////////////////////////////////////////////////////////////////////
  // selector codes and reset values
  localparam logic [4:0] SEL_GROUND    = 5'h1f;
  localparam logic [4:0] SEL_NULL      = 5'h00;
  localparam logic [4:0] SEL_TX        = 5'h03;
  localparam logic [4:0] SEL_RTS       = 5'h04;
  localparam logic [4:0] SEL_SDO       = 5'h07;
  localparam logic [4:0] SEL_SCK       = 5'h08;
  localparam logic [4:0] SEL_SS        = 5'h09;
  localparam logic [4:0] SEL_OC1       = 5'h12;
  localparam logic [4:0] SEL_OC2       = 5'h13;
  localparam logic [4:0] IN_SEL_RESET  = 5'h1f;
  localparam logic [4:0] OUT_SEL_RESET = 5'h00;
  localparam logic [7:0] CFG_RESET     = 8'hff;
  localparam logic [IMAGE_W-1:0] IMAGE_RESET =
    {{NUM_PINS{OUT_SEL_RESET}}, {NUM_IN{IN_SEL_RESET}}};

  // peripheral output indices
  localparam logic [2:0] POUT_TX  = 3'h0;
  localparam logic [2:0] POUT_RTS = 3'h1;
  localparam logic [2:0] POUT_SDO = 3'h2;
  localparam logic [2:0] POUT_SCK = 3'h3;
  localparam logic [2:0] POUT_SS  = 3'h4;
  localparam logic [2:0] POUT_OC1 = 3'h5;
  localparam logic [2:0] POUT_OC2 = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // unlock key sequence
  localparam logic [7:0] KEY_FIRST  = 8'h46;
  localparam logic [7:0] KEY_SECOND = 8'h57;

  typedef enum logic [2:0] {
    UNL_IDLE = 3'b001,
    UNL_KEY1 = 3'b010,
    UNL_KEY2 = 3'b100
  } unlock_state_type;

endpackage

/* route_unlock.sv */
// route_unlock: key sequence and lock bit for the routing registers
// assumes write strobes and data on the same clock as the block
`timescale 1ns/100ps
module route_unlock (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  // write observation
  input  wire logic       i_osc_write,
  input  wire logic       i_any_write,
  input  wire logic [7:0] i_wdata_low,
  input  wire logic       i_fuse_active,
  // lock state
  output logic            o_lock
);
  import pin_routing_pkg::*;

  unlock_state_type state_reg;
  logic             lock_reg;
  logic             frozen;

  // a set lock under the fuse is permanent until reset
  assign frozen = i_fuse_active && lock_reg;

  // RULE15: key sequence
  // RULE25: stray write abandons
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= UNL_IDLE;
    end else begin
      case (state_reg)
        UNL_IDLE: begin
          if (i_osc_write && i_wdata_low == KEY_FIRST && !frozen) begin
            state_reg <= UNL_KEY1;
          end
        end
        UNL_KEY1: begin
          if (i_osc_write && i_wdata_low == KEY_SECOND) begin
            state_reg <= UNL_KEY2;
          end else if (i_any_write) begin
            state_reg <= UNL_IDLE;
          end
        end
        UNL_KEY2: begin
          if (i_any_write) begin
            state_reg <= UNL_IDLE;
          end
        end
        default: state_reg <= UNL_IDLE;
      endcase
    end
  end

  // RULE16: lock holds until changed
  // RULE18: fuse blocks clearing
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lock_reg <= 1'b0;
    end else if (state_reg == UNL_KEY2 && i_osc_write && !frozen) begin
      lock_reg <= i_wdata_low[LOCK_BIT];
    end
  end

  assign o_lock = lock_reg;

endmodule // route_unlock

/* route_shadow.sv */
// route_shadow: shadow copy of every routing selector
// assumes i_load pulses in the cycle a routing write is accepted
`timescale 1ns/100ps
module route_shadow (
  // clock and reset
  input  wire logic                                i_clock,
  input  wire logic                                i_arst_n,
  // live image
  input  wire logic [pin_routing_pkg::IMAGE_W-1:0] i_image,
  input  wire logic                                i_load,
  // mismatch
  output logic                                     o_mismatch
);
  import pin_routing_pkg::*;

  logic [IMAGE_W-1:0] shadow_reg;
  logic               load_pend_reg;
  logic               mismatch_reg;

  // image changes one edge after the write, so the copy follows then
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      load_pend_reg <= 1'b0;
      shadow_reg    <= IMAGE_RESET;
    end else begin
      load_pend_reg <= i_load;
      if (load_pend_reg) begin
        shadow_reg <= i_image;
      end
    end
  end

  // RULE17: compare continuously
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mismatch_reg <= 1'b0;
    end else begin
      mismatch_reg <= !load_pend_reg && (i_image != shadow_reg);
    end
  end

  assign o_mismatch = mismatch_reg;

endmodule // route_shadow

/* remappable_pin_select.sv */
// remappable_pin_select: routing of peripheral inputs and outputs
// onto the remappable pins, with write protection and monitoring
// assumes a same-clock register port, peripherals and port latch logic
// on this clock, and pins arriving asynchronously
//
// Notes on behaviour
// RULE1: each peripheral input has its own 5-bit pin selector
// RULE2: selector value n connects remappable pin n to the input
// RULE3: code 11111 grounds the input; 00000..01111 pick pins 0..15
// RULE4: selector codes beyond the supported pins give no pin
// RULE5: software sets a mapped input pin's direction bit to input
// RULE6: input and output routing are controlled independently
// RULE7: each remappable pin has its own 5-bit output selector
// RULE8: output code 00000 leaves the pin to its port function
// RULE9: codes 00011 and 00100 route serial transmit and rts
// RULE10: codes 00111, 01000, 01001 route spi data, clock, select
// RULE11: codes 10010 and 10011 route compare channels one and two
// RULE12: fourteen routable inputs: interrupts, timers, captures, serial, spi
// RULE13: writes while locked finish normally but change nothing
// RULE14: lock bit at bit 6 of the oscillator control register
// RULE15: lock changes only after keys 0x46, 0x57 then one write
// RULE16: lock bit holds its value until explicitly changed
// RULE17: shadow copies compare continuously; difference forces reset
// RULE18: with fuse active, a set lock clears only by reset
// RULE19: fuse is active unprogrammed; programmed allows many sessions
// RULE20: nine input and eight output routing registers
// RULE21: external interrupt 1 selector at bits 12..8 of register 0
// RULE22: unimplemented routing register bits read as zero
// RULE23: input selectors reset to ones, inputs start grounded
// RULE24: a pin driven by a peripheral disables its port driver
// RULE25: any stray write mid-sequence abandons the unlock
`timescale 1ns/100ps
module remappable_pin_select (
  // clock and reset
  input  wire logic                                 i_clock,
  input  wire logic                                 i_arst_n,
  // register port
  input  wire logic [pin_routing_pkg::ADDR_W-1:0]   i_reg_addr,
  input  wire logic [pin_routing_pkg::DATA_W-1:0]   i_reg_wdata,
  input  wire logic                                 i_reg_write,
  input  wire logic                                 i_reg_read,
  output logic      [pin_routing_pkg::DATA_W-1:0]   o_reg_rdata,
  // configuration word
  input  wire logic [pin_routing_pkg::CFG_W-1:0]    i_osc_config_word,
  // remappable pins
  input  wire logic [pin_routing_pkg::NUM_PINS-1:0] i_pin_in,
  output logic      [pin_routing_pkg::NUM_PINS-1:0] o_pin_out,
  output logic      [pin_routing_pkg::NUM_PINS-1:0] o_pin_oe,
  output logic      [pin_routing_pkg::NUM_PINS-1:0] o_pin_level,
  // default port function
  input  wire logic [pin_routing_pkg::NUM_PINS-1:0] i_port_out,
  input  wire logic [pin_routing_pkg::NUM_PINS-1:0] i_port_oe,
  output logic      [pin_routing_pkg::NUM_PINS-1:0] o_port_overridden,
  // peripheral side
  input  wire logic [pin_routing_pkg::NUM_POUT-1:0] i_periph_out,
  input  wire logic [pin_routing_pkg::NUM_POUT-1:0] i_periph_oe,
  output logic      [pin_routing_pkg::NUM_IN-1:0]   o_periph_in,
  // status
  output logic                                      o_route_lock,
  output logic                                      o_mismatch_reset
);
  import pin_routing_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [NUM_PINS-1:0] pin_meta_reg;
  logic [NUM_PINS-1:0] pin_sync_reg;
  logic [CFG_W-1:0]    cfg_meta_reg;
  logic [CFG_W-1:0]    cfg_sync_reg;

  logic [SEL_W-1:0]    in_sel_reg  [NUM_IN];
  logic [SEL_W-1:0]    out_sel_reg [NUM_PINS];

  logic                lock;
  logic                fuse_active;
  logic                osc_write;
  logic                route_wr_ok;
  logic                route_wr_hit;

  logic [DATA_W-1:0]   rdata_next;
  logic [DATA_W-1:0]   rdata_reg;

  logic [NUM_IN-1:0]   periph_in_next;
  logic [NUM_IN-1:0]   periph_in_reg;
  logic [NUM_PINS-1:0] pin_out_next;
  logic [NUM_PINS-1:0] pin_out_reg;
  logic [NUM_PINS-1:0] pin_oe_next;
  logic [NUM_PINS-1:0] pin_oe_reg;
  logic [NUM_PINS-1:0] override_next;
  logic [NUM_PINS-1:0] override_reg;

  logic [IMAGE_W-1:0]  image;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic in_reg_hit(input logic [ADDR_W-1:0] addr);
    in_reg_hit = (addr >= IN_ROUTE_BASE) && (addr <= IN_ROUTE_LAST);
  endfunction

  function automatic logic out_reg_hit(input logic [ADDR_W-1:0] addr);
    out_reg_hit = (addr >= OUT_ROUTE_BASE) && (addr <= OUT_ROUTE_LAST);
  endfunction

  function automatic logic [ADDR_W-1:0] out_reg_addr(input int pin);
    out_reg_addr = OUT_ROUTE_BASE + ADDR_W'(pin / 2);
  endfunction

  function automatic int out_lsb(input int pin);
    out_lsb = (pin % 2) * OUT_HI_LSB;
  endfunction

  // output selector to peripheral index; bit 3 flags a known code
  function automatic logic [3:0] out_decode(input logic [SEL_W-1:0] sel);
    case (sel)
      SEL_TX:  out_decode = {1'b1, POUT_TX};
      SEL_RTS: out_decode = {1'b1, POUT_RTS};
      SEL_SDO: out_decode = {1'b1, POUT_SDO};
      SEL_SCK: out_decode = {1'b1, POUT_SCK};
      SEL_SS:  out_decode = {1'b1, POUT_SS};
      SEL_OC1: out_decode = {1'b1, POUT_OC1};
      SEL_OC2: out_decode = {1'b1, POUT_OC2};
      default: out_decode = 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin and configuration synchronisers

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_meta_reg <= 16'h0000;
      pin_sync_reg <= 16'h0000;
    end else begin
      pin_meta_reg <= i_pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // resets to all ones so the fuse counts as active until sampled
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cfg_meta_reg <= CFG_RESET;
      cfg_sync_reg <= CFG_RESET;
    end else begin
      cfg_meta_reg <= i_osc_config_word;
      cfg_sync_reg <= cfg_meta_reg;
    end
  end

  // RULE19: unprogrammed fuse is active
  assign fuse_active = cfg_sync_reg[FUSE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // write protection

  assign osc_write = i_reg_write && (i_reg_addr == OSC_CTRL_ADDR);

  // RULE14: lock bit in oscillator control
  route_unlock u_unlock (
    .i_clock       (i_clock),
    .i_arst_n      (i_arst_n),
    .i_osc_write   (osc_write),
    .i_any_write   (i_reg_write),
    .i_wdata_low   (i_reg_wdata[7:0]),
    .i_fuse_active (fuse_active),
    .o_lock        (lock)
  );

  // RULE13: locked writes dropped silently
  assign route_wr_ok  = i_reg_write && !lock;
  assign route_wr_hit = route_wr_ok &&
                        (in_reg_hit(i_reg_addr) || out_reg_hit(i_reg_addr));

  ////////////////////////////////////////////////////////////////////////////
  // input selectors

  // RULE1: one selector per input
  // RULE12: fourteen routed inputs
  // RULE21: interrupt 1 in bits 12..8
  generate
    for (genvar g = 0; g < NUM_IN; g++) begin : g_in_sel
      // RULE23: reset to ground code
      always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
          in_sel_reg[g] <= IN_SEL_RESET;
        end else if (route_wr_ok && i_reg_addr == IN_REG_ADDR[g]) begin
          in_sel_reg[g] <= i_reg_wdata[IN_LSB[g] +: SEL_W];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // output selectors

  // RULE7: one selector per pin
  // RULE20: eight output registers
  generate
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_out_sel
      always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
          out_sel_reg[p] <= OUT_SEL_RESET;
        end else if (route_wr_ok && i_reg_addr == out_reg_addr(p)) begin
          out_sel_reg[p] <= i_reg_wdata[out_lsb(p) +: SEL_W];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register read

  // RULE22: unused bits read zero
  always_comb begin
    rdata_next = 16'h0000;
    if (in_reg_hit(i_reg_addr)) begin
      for (int f = 0; f < NUM_IN; f++) begin
        if (i_reg_addr == IN_REG_ADDR[f]) begin
          rdata_next[IN_LSB[f] +: SEL_W] = in_sel_reg[f];
        end
      end
    end else if (out_reg_hit(i_reg_addr)) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        if (i_reg_addr == out_reg_addr(p)) begin
          rdata_next[out_lsb(p) +: SEL_W] = out_sel_reg[p];
        end
      end
    end else if (i_reg_addr == OSC_CTRL_ADDR) begin
      rdata_next[LOCK_BIT] = lock;
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_reg <= 16'h0000;
    end else if (i_reg_read) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input routing

  // RULE2: value n picks pin n
  // RULE3: ground code and pin codes
  // RULE4: unsupported codes give ground
  always_comb begin
    periph_in_next = 14'h0000;
    for (int f = 0; f < NUM_IN; f++) begin
      if (!in_sel_reg[f][SEL_W-1]) begin
        periph_in_next[f] = pin_sync_reg[in_sel_reg[f][3:0]];
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      periph_in_reg <= 14'h0000;
    end else begin
      periph_in_reg <= periph_in_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output routing

  // RULE6: separate from input routing
  // RULE8: null code keeps port
  // RULE9: serial outputs
  // RULE10: spi outputs
  // RULE11: compare outputs
  // RULE24: peripheral drive overrides port
  always_comb begin
    logic [3:0] dec;
    dec           = 4'h0;
    pin_out_next  = 16'h0000;
    pin_oe_next   = 16'h0000;
    override_next = 16'h0000;
    for (int p = 0; p < NUM_PINS; p++) begin
      dec = out_decode(out_sel_reg[p]);
      if (dec[3] && i_periph_oe[dec[2:0]]) begin
        pin_out_next[p]  = i_periph_out[dec[2:0]];
        pin_oe_next[p]   = 1'b1;
        override_next[p] = 1'b1;
      end else begin
        pin_out_next[p]  = i_port_out[p];
        pin_oe_next[p]   = i_port_oe[p];
      end
    end
  end

  // a mapped peripheral that is not driving hands the pin back to the port
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_out_reg  <= 16'h0000;
      pin_oe_reg   <= 16'h0000;
      override_reg <= 16'h0000;
    end else begin
      pin_out_reg  <= pin_out_next;
      pin_oe_reg   <= pin_oe_next;
      override_reg <= override_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shadow monitoring

  generate
    for (genvar f = 0; f < NUM_IN; f++) begin : g_img_in
      assign image[f*SEL_W +: SEL_W] = in_sel_reg[f];
    end
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_img_out
      assign image[(NUM_IN+p)*SEL_W +: SEL_W] = out_sel_reg[p];
    end
  endgenerate

  // RULE17: mismatch forces reset
  route_shadow u_shadow (
    .i_clock    (i_clock),
    .i_arst_n   (i_arst_n),
    .i_image    (image),
    .i_load     (route_wr_hit),
    .o_mismatch (o_mismatch_reset)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_reg_rdata       = rdata_reg;
  assign o_periph_in       = periph_in_reg;
  assign o_pin_out         = pin_out_reg;
  assign o_pin_oe          = pin_oe_reg;
  assign o_port_overridden = override_reg;
  // pins stay readable whoever drives them
  assign o_pin_level       = pin_sync_reg;
  assign o_route_lock      = lock;

endmodule // remappable_pin_select

/* route_props.sv */
// route_props: concurrent checks on the remappable pin routing block
// assumes one clock domain and the register map of the package
`timescale 1ns/100ps
module route_props (
  // clock and reset
  input  wire logic                                 i_clock,
  input  wire logic                                 i_arst_n,
  // register port
  input  wire logic [pin_routing_pkg::ADDR_W-1:0]   i_reg_addr,
  input  wire logic [pin_routing_pkg::DATA_W-1:0]   i_reg_wdata,
  input  wire logic                                 i_reg_write,
  input  wire logic                                 i_reg_read,
  input  wire logic [pin_routing_pkg::DATA_W-1:0]   o_reg_rdata,
  input  wire logic [pin_routing_pkg::CFG_W-1:0]    i_osc_config_word,
  // pins and status
  input  wire logic [pin_routing_pkg::NUM_PINS-1:0] o_pin_oe,
  input  wire logic [pin_routing_pkg::NUM_PINS-1:0] o_port_overridden,
  input  wire logic                                 o_route_lock,
  input  wire logic                                 o_mismatch_reset
);
  import pin_routing_pkg::*;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  ////////////////////////////////////////////////////////////////////////////
  chk_reserved_zero: assert property ($past(i_reg_read && (i_reg_addr <= IN_ROUTE_LAST ||
    (i_reg_addr >= OUT_ROUTE_BASE && i_reg_addr <= OUT_ROUTE_LAST)))
    |-> (o_reg_rdata & 16'he0e0) == 16'h0000) else $error("reserved routing bits not zero");
  chk_int1_field: assert property ($past(i_reg_read && i_reg_addr == IN_ROUTE_BASE)
    |-> o_reg_rdata[7:0] == 8'h00) else $error("low byte of interrupt one register not zero");
  chk_lock_by_key: assert property ($changed(o_route_lock) |-> $past(i_reg_write &&
    i_reg_addr == OSC_CTRL_ADDR && i_reg_wdata[LOCK_BIT] != o_route_lock))
    else $error("lock changed without a control write");
  chk_lock_holds: assert property (!$past(i_reg_write) |-> $stable(o_route_lock))
    else $error("lock moved with no write");
  // three past samples cover the fuse synchroniser delay
  chk_single_session: assert property (o_route_lock && $past(i_osc_config_word[FUSE_BIT]) &&
    $past(i_osc_config_word[FUSE_BIT], 2) && $past(i_osc_config_word[FUSE_BIT], 3)
    |=> o_route_lock) else $error("lock cleared while fuse active");
  chk_lock_readback: assert property ($past(i_reg_read && i_reg_addr == OSC_CTRL_ADDR)
    |-> o_reg_rdata == {9'h000, $past(o_route_lock), 6'h00}) else $error("lock readback wrong");
  chk_port_released: assert property ((o_port_overridden & ~o_pin_oe) == 16'h0000)
    else $error("overridden pin not driven");
  chk_no_mismatch: assert property (!o_mismatch_reset)
    else $error("mismatch reset in normal operation");
endmodule // route_props

bind remappable_pin_select route_props i_route_props (.i_clock, .i_arst_n, .i_reg_addr,
  .i_reg_wdata, .i_reg_write, .i_reg_read, .o_reg_rdata, .i_osc_config_word, .o_pin_oe,
  .o_port_overridden, .o_route_lock, .o_mismatch_reset);

/* periph_pin_model.sv */
// periph_pin_model: peripherals and pin levels around the routing block
// assumes the bench pulses i_step to draw a new random state
`timescale 1ns/100ps
module periph_pin_model (
  // control
  input  wire logic        i_clock,
  input  wire logic        i_step,
  input  wire logic [15:0] i_input_mask,
  // pins and port
  output logic      [15:0] o_pin_in,
  output logic      [15:0] o_port_out,
  output logic      [15:0] o_port_oe,
  // peripherals
  output logic      [6:0]  o_periph_out,
  output logic      [6:0]  o_periph_oe
);
  initial begin
    o_pin_in = '0;
    o_port_out = '0;
    o_port_oe = '0;
    o_periph_out = '0;
    o_periph_oe = '0;
  end
  always @(posedge i_clock) begin
    if (i_step) begin
      o_pin_in <= 16'($urandom);
      o_port_out <= 16'($urandom);
      o_port_oe <= 16'($urandom) & ~i_input_mask;
      o_periph_out <= 7'($urandom);
      o_periph_oe <= 7'($urandom);
    end
  end
endmodule // periph_pin_model

/* remappable_pin_select_test.sv */
// remappable_pin_select_test: self-checking bench for the routing block
// assumes the peripheral model on the pin side and a 10 MHz clock
`timescale 1ns/100ps
module remappable_pin_select_test;
  import pin_routing_pkg::*;
  typedef struct {int kind; logic [15:0] exp;} note_type;
  logic clock = 1'b0, arst_n = 1'b0, write = 1'b0, read = 1'b0, step = 1'b0, probe = 1'b0;
  logic [5:0] addr = '0;
  logic [15:0] wdata = '0, in_pins = '0, msk, eo, eoe, eov, rdata, pin_out, pin_oe;
  logic [15:0] pin_level, overridden, pin_in, port_out, port_oe, d[17], fm[17];
  logic [7:0] cfg = 8'hff;
  logic [6:0] periph_out, periph_oe;
  logic [13:0] periph_in, ep;
  logic [5:0] ad[17];
  logic [4:0] sel[14], oc[16];
  logic [4:0] codes[10] = '{5'h00, 5'h03, 5'h04, 5'h07, 5'h08, 5'h09, 5'h12, 5'h13, 5'h05, 5'h1f};
  logic lock, mism, rd_prev = 1'b0;
  note_type notes[$];
  int failures = 0, n_checks = 0, m;

  always #50 clock = ~clock;

  remappable_pin_select i_remappable_pin_select (.i_clock(clock), .i_arst_n(arst_n),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_write(write), .i_reg_read(read),
    .o_reg_rdata(rdata), .i_osc_config_word(cfg), .i_pin_in(pin_in), .o_pin_out(pin_out),
    .o_pin_oe(pin_oe), .o_pin_level(pin_level), .i_port_out(port_out), .i_port_oe(port_oe),
    .o_port_overridden(overridden), .i_periph_out(periph_out), .i_periph_oe(periph_oe),
    .o_periph_in(periph_in), .o_route_lock(lock), .o_mismatch_reset(mism));
  periph_pin_model i_periph_pin_model (.i_clock(clock), .i_step(step), .i_input_mask(in_pins),
    .o_pin_in(pin_in), .o_port_out(port_out), .o_port_oe(port_oe),
    .o_periph_out(periph_out), .o_periph_oe(periph_oe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // outputs are compared at the falling edge, well clear of updates
  always @(posedge clock) rd_prev <= read;
  always @(negedge clock) begin : monitor
    note_type n;
    if (rd_prev || probe) begin
      n = notes.pop_front();
      case (n.kind)
        0: check(rdata, n.exp);
        1: check({2'b00, periph_in}, n.exp);
        2: check(pin_out, n.exp);
        3: check(pin_oe, n.exp);
        4: check(overridden, n.exp);
        6: check({14'h0000, lock, mism}, n.exp);
        default: check(pin_level, n.exp);
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge clock);
    addr <= a;
    wdata <= v;
    write <= 1'b1;
    @(posedge clock);
    write <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    notes.push_back('{0, e});
    @(posedge clock);
    addr <= a;
    read <= 1'b1;
    @(posedge clock);
    read <= 1'b0;
  endtask
  task automatic look(input int k, input logic [15:0] e);
    notes.push_back('{k, e});
    @(posedge clock);
    probe <= 1'b1;
    @(posedge clock);
    probe <= 1'b0;
  endtask
  task automatic unlock(input logic [7:0] v);
    wr(OSC_CTRL_ADDR, 16'h0046);
    wr(OSC_CTRL_ADDR, 16'h0057);
    wr(OSC_CTRL_ADDR, {8'h00, v});
  endtask
  task automatic do_reset(input logic [7:0] c);
    // let the answer of a last read stand before reset clears it
    if (arst_n) @(posedge clock);
    arst_n <= 1'b0;
    cfg <= c;
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
  endtask
  function automatic int omap(input logic [4:0] c);
    case (c)
      5'h03: return 0;
      5'h04: return 1;
      5'h07: return 2;
      5'h08: return 3;
      5'h09: return 4;
      5'h12: return 5;
      5'h13: return 6;
      default: return -1;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    summarize();
  end
  initial begin
    void'($urandom(86889));
    for (int a = 0; a < 17; a++) begin
      ad[a] = (a < 9) ? 6'(a) : OUT_ROUTE_BASE + 6'(a - 9);
      fm[a] = (a < 9) ? 16'h0000 : 16'h1f1f;
    end
    for (int k = 0; k < NUM_IN; k++) fm[IN_REG_ADDR[k]][IN_LSB[k] +: 5] = 5'h1f;
    do_reset(8'hff);
    for (int a = 0; a < 17; a++) rd(ad[a], (a < 9) ? fm[a] : 16'h0000);
    rd(OSC_CTRL_ADDR, 16'h0000);
    rd(6'h3f, 16'h0000);
    for (int r = 0; r < 6; r++) begin
      msk = '0;
      for (int a = 0; a < 17; a++) d[a] = '0;
      for (int k = 0; k < NUM_IN; k++) begin
        sel[k] = 5'($urandom_range(0, 31));
        d[IN_REG_ADDR[k]][IN_LSB[k] +: 5] = sel[k];
        if (!sel[k][4]) msk[sel[k][3:0]] = 1'b1;
      end
      for (int p = 0; p < 16; p++) begin
        oc[p] = codes[$urandom_range(0, 9)];
        d[9 + p / 2][8 * (p % 2) +: 5] = oc[p];
      end
      for (int a = 0; a < 17; a++) wr(ad[a], d[a] | (16'($urandom) & ~fm[a]));
      for (int a = 0; a < 17; a++) rd(ad[a], d[a]);
      in_pins <= msk;
      @(posedge clock) step <= 1'b1;
      @(posedge clock) step <= 1'b0;
      repeat (4) @(posedge clock);
      for (int k = 0; k < NUM_IN; k++) ep[k] = sel[k][4] ? 1'b0 : pin_in[sel[k][3:0]];
      for (int p = 0; p < 16; p++) begin
        m = omap(oc[p]);
        if (m >= 0 && periph_oe[m] === 1'b1) {eo[p], eoe[p], eov[p]} = {periph_out[m], 2'b11};
        else {eo[p], eoe[p], eov[p]} = {port_out[p], port_oe[p], 1'b0};
      end
      look(1, {2'b00, ep});
      look(2, eo);
      look(3, eoe);
      look(4, eov);
      look(5, pin_in);
    end
    unlock(8'h40);
    rd(OSC_CTRL_ADDR, 16'h0040);
    look(6, 16'h0002);
    wr(6'h01, 16'h0000);
    rd(6'h01, d[1]);
    unlock(8'h00);
    rd(OSC_CTRL_ADDR, 16'h0040);
    // second reset with the fuse programmed
    do_reset(8'hdf);
    wr(OSC_CTRL_ADDR, 16'h0046);
    wr(6'h3f, 16'h0000);
    wr(OSC_CTRL_ADDR, 16'h0057);
    wr(OSC_CTRL_ADDR, 16'h0040);
    rd(OSC_CTRL_ADDR, 16'h0000);
    unlock(8'h40);
    wr(6'h02, 16'h0000);
    rd(OSC_CTRL_ADDR, 16'h0040);
    unlock(8'h00);
    rd(OSC_CTRL_ADDR, 16'h0000);
    wr(6'h01, 16'h0003);
    rd(6'h01, 16'h0003);
    summarize();
  end
endmodule // remappable_pin_select_test
